/* File: design/imc_mode_ctrl.sv */
// Summary of operation
// - route bit 0: field is priority level, 000 disables, 001-111 levels 1-7
// - route bit 1 turns the source into a dma start request
// - route bit 1: field 000-011 picks dma channel, 100-111 invalid
// - byte 0 configures source 32, serial 4 transmit
// - byte 1 configures source 33, serial 5 receive, same layout
// - byte 2 configures source 34, serial 5 transmit, same layout
module imc_mode_ctrl (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic      [1:0]  hresp,
   output logic      [31:0] hrdata,
   input  wire logic        serial4_transmit_irq,
   input  wire logic        serial5_receive_irq,
   input  wire logic        serial5_transmit_irq,
   output logic      [2:0]  src32_level,
   output logic      [2:0]  src33_level,
   output logic      [2:0]  src34_level,
   output logic      [2:0]  cpu_irq_req,
   output logic      [3:0]  dma_start,
   output logic             irq
);

   typedef struct packed {
      logic [31:0] mode;
      logic [2:0]  stat;
      logic [2:0]  mask;
      logic        wr_mode;
      logic        wr_stat;
      logic        wr_mask;
      logic [31:0] rdata;
      logic [8:0]  level;
      logic [2:0]  cpu_req;
      logic [3:0]  dma;
   } imc_state_t;

   imc_state_t st;
   imc_state_t next_st;

   logic [2:0]  src_irq;
   logic [8:0]  src_level;
   logic [2:0]  src_cpu;
   logic [11:0] src_dma;
   logic [2:0]  src_bad_dma;
   logic [2:0]  src_bad_edge;
   logic        addr_phase;
   logic [3:0]  dma_any;
   logic [2:0]  events;
   logic [2:0]  clr_bits;

   // address match used for both read and write decode
   function automatic logic hit(input logic [31:0] a, input logic [31:0] reg_addr);
      hit = (a == reg_addr);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // per-source decode, one byte of the mode register each
   assign src_irq = {serial5_transmit_irq, serial5_receive_irq, serial4_transmit_irq};

   for (genvar i = 0; i < imc_pkg::IMC_NUM_SRC; i++) begin : g_src
      imc_src_route u_route (
         .cfg       (st.mode[i*imc_pkg::IMC_BYTE_W +: imc_pkg::IMC_BYTE_W]),
         .irq       (src_irq[i]),
         .level_out (src_level[i*imc_pkg::IMC_FLD_W +: imc_pkg::IMC_FLD_W]),
         .cpu_req   (src_cpu[i]),
         .dma_req   (src_dma[i*imc_pkg::IMC_DMA_CH +: imc_pkg::IMC_DMA_CH]),
         .bad_dma   (src_bad_dma[i]),
         .bad_edge  (src_bad_edge[i])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // merge dma requests of all sources per channel
   always_comb begin
      dma_any = '0;
      for (int i = 0; i < imc_pkg::IMC_NUM_SRC; i++) begin
         dma_any = dma_any | src_dma[i*imc_pkg::IMC_DMA_CH +: imc_pkg::IMC_DMA_CH];
      end
   end

   // event vector feeding the sticky status register
   always_comb begin
      events                         = '0;
      events[imc_pkg::IMC_ST_DMA]     = |dma_any;
      events[imc_pkg::IMC_ST_BADDMA]  = |src_bad_dma;
      events[imc_pkg::IMC_ST_BADEDGE] = |src_bad_edge;
   end

   assign addr_phase = hsel & htrans[imc_pkg::IMC_HTRANS_ACT] & hready;
   assign clr_bits   = st.wr_stat ? hwdata[imc_pkg::IMC_ST_W-1:0] : '0;

   ////////////////////////////////////////////////////////////////////////////
   // next state: bus writes, status, read data and registered outputs
   always_comb begin
      next_st = st;

      // data phase of a write taken in the previous address phase
      if (st.wr_mode) begin
         next_st.mode = hwdata & imc_pkg::IMC_MODE_WMASK;
      end
      if (st.wr_mask) begin
         next_st.mask = hwdata[imc_pkg::IMC_ST_W-1:0];
      end
      // write one to clear; a new event in the same cycle wins
      next_st.stat = (st.stat & ~clr_bits) | events;

      // address phase decode; unmapped addresses are ignored
      next_st.wr_mode = addr_phase & hwrite & hit(haddr, imc_pkg::IMC_MODE_ADDR);
      next_st.wr_stat = addr_phase & hwrite & hit(haddr, imc_pkg::IMC_STAT_ADDR);
      next_st.wr_mask = addr_phase & hwrite & hit(haddr, imc_pkg::IMC_MASK_ADDR);

      // read data from post-write values so back-to-back write then read is current
      if (addr_phase && !hwrite) begin
         next_st.rdata = '0;
         if (hit(haddr, imc_pkg::IMC_MODE_ADDR)) begin
            next_st.rdata = next_st.mode;
         end else if (hit(haddr, imc_pkg::IMC_STAT_ADDR)) begin
            next_st.rdata[imc_pkg::IMC_ST_W-1:0] = next_st.stat;
         end else if (hit(haddr, imc_pkg::IMC_MASK_ADDR)) begin
            next_st.rdata[imc_pkg::IMC_ST_W-1:0] = next_st.mask;
         end
      end

      // outputs toward processor core and dma controller
      next_st.level   = src_level;
      next_st.cpu_req = src_cpu;
      next_st.dma     = dma_any;
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st         <= '0;
         st.mode    <= imc_pkg::IMC_MODE_RESET;
         st.stat    <= imc_pkg::IMC_STAT_RESET;
         st.mask    <= imc_pkg::IMC_MASK_RESET;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // output assignments
   assign hreadyout   = 1'b1;              // zero wait states
   assign hresp       = imc_pkg::IMC_HRESP_OK;
   assign hrdata      = st.rdata;
   assign src32_level = st.level[0 +: imc_pkg::IMC_FLD_W];
   assign src33_level = st.level[imc_pkg::IMC_FLD_W +: imc_pkg::IMC_FLD_W];
   assign src34_level = st.level[2*imc_pkg::IMC_FLD_W +: imc_pkg::IMC_FLD_W];
   assign cpu_irq_req = st.cpu_req;
   assign dma_start   = st.dma;
   assign irq         = |(st.stat & st.mask);

endmodule // imc_mode_ctrl

/* File: design/imc_pkg.sv */
package imc_pkg;

   // register byte addresses on the AHB-Lite bus
   localparam logic [31:0] IMC_MODE_ADDR  = 32'hFFFF_E020;
   localparam logic [31:0] IMC_STAT_ADDR  = 32'hFFFF_E0F0;
   localparam logic [31:0] IMC_MASK_ADDR  = 32'hFFFF_E0F4;

   // reset values
   localparam logic [31:0] IMC_MODE_RESET = 32'h0000_0000;
   localparam logic [2:0]  IMC_STAT_RESET = 3'h0;
   localparam logic [2:0]  IMC_MASK_RESET = 3'h0;

   // bits 7:6 of every byte have no storage and read as zero
   localparam logic [31:0] IMC_MODE_WMASK = 32'h3F3F_3F3F;

   // layout of one source byte
   localparam int          IMC_NUM_SRC    = 3;
   localparam int          IMC_BYTE_W     = 8;
   localparam int          IMC_FLD_LSB    = 0;
   localparam int          IMC_FLD_W      = 3;
   localparam int          IMC_ROUTE_BIT  = 3;
   localparam int          IMC_EDGE_LSB   = 4;
   localparam int          IMC_EDGE_W     = 2;
   localparam int          IMC_DMA_CH     = 4;

   // field codes
   localparam logic [2:0]  IMC_LEVEL_OFF  = 3'h0;
   localparam logic [2:0]  IMC_DMA_MAX    = 3'h3;
   localparam logic [1:0]  IMC_EDGE_REQ   = 2'h3;
   localparam logic [3:0]  IMC_DMA_ONE    = 4'h1;

   // sticky status bits (status and mask share this layout)
   localparam int          IMC_ST_W       = 3;
   localparam int          IMC_ST_DMA     = 0;
   localparam int          IMC_ST_BADDMA  = 1;
   localparam int          IMC_ST_BADEDGE = 2;

   // ahb-lite encodings
   localparam int          IMC_HTRANS_ACT = 1;
   localparam logic [1:0]  IMC_HRESP_OK   = 2'h0;

endpackage : imc_pkg

/* File: design/imc_src_route.sv */
// one interrupt source: splits its mode byte into processor or dma use
module imc_src_route (
   input  wire logic [7:0] cfg,
   input  wire logic       irq,
   output logic      [2:0] level_out,
   output logic            cpu_req,
   output logic      [3:0] dma_req,
   output logic            bad_dma,
   output logic            bad_edge
);

   logic       route;
   logic [2:0] fld;
   logic [1:0] edge_mode;
   logic       dma_ok;

   ////////////////////////////////////////////////////////////////////////////
   // field extraction
   assign route     = cfg[imc_pkg::IMC_ROUTE_BIT];
   assign fld       = cfg[imc_pkg::IMC_FLD_LSB +: imc_pkg::IMC_FLD_W];
   assign edge_mode = cfg[imc_pkg::IMC_EDGE_LSB +: imc_pkg::IMC_EDGE_W];
   assign dma_ok    = (fld <= imc_pkg::IMC_DMA_MAX);

   ////////////////////////////////////////////////////////////////////////////
   // processor path: level only when not routed, code zero disables
   assign level_out = route ? imc_pkg::IMC_LEVEL_OFF : fld;
   assign cpu_req   = irq & ~route & (fld != imc_pkg::IMC_LEVEL_OFF);

   // dma path: one start request to the channel named by the field
   always_comb begin
      dma_req = '0;
      if (irq && route && dma_ok) begin
         dma_req = imc_pkg::IMC_DMA_ONE << fld[1:0];
      end
   end

   // invalid channel codes start nothing and are reported instead
   assign bad_dma  = irq & route & ~dma_ok;
   assign bad_edge = irq & (edge_mode != imc_pkg::IMC_EDGE_REQ);

endmodule // imc_src_route

/* File: verif/imc_far_side.sv */
module imc_far_side (
   input wire logic       hclk,
   input wire logic       hresetn,
   input wire logic [3:0] dma_start,
   output logic     [7:0] dma_seen
);
   timeunit 1ns;
   timeprecision 1ps;
   // dma controller side: counts every start request it receives
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dma_seen <= 8'h00;
      end else begin
         dma_seen <= dma_seen + 8'($countones(dma_start));
      end
   end
endmodule // imc_far_side

/* File: verif/imc_mode_ctrl_chk.sv */
module imc_mode_ctrl_chk (
   input wire logic       hclk,
   input wire logic       hresetn,
   input wire logic       serial4_transmit_irq,
   input wire logic       serial5_receive_irq,
   input wire logic       serial5_transmit_irq,
   input wire logic [2:0] src32_level,
   input wire logic [2:0] src33_level,
   input wire logic [2:0] src34_level,
   input wire logic [2:0] cpu_irq_req,
   input wire logic [3:0] dma_start
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] src;
   logic [2:0] lvz;
   // source events and level-zero flags gathered per source
   assign src = {serial5_transmit_irq, serial5_receive_irq, serial4_transmit_irq};
   assign lvz = {src34_level == 3'h0, src33_level == 3'h0, src32_level == 3'h0};
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // processor request one cycle after an event, only with a nonzero level
   a_cpu_src32: assert property (cpu_irq_req[0] == ($past(src[0]) && !lvz[0]))
      else $error("source 32 request wrong");
   a_cpu_src33: assert property (cpu_irq_req[1] == ($past(src[1]) && !lvz[1]))
      else $error("source 33 request wrong");
   a_cpu_src34: assert property (cpu_irq_req[2] == ($past(src[2]) && !lvz[2]))
      else $error("source 34 request wrong");
   // dma starts only come from an event of a routed source
   a_dma_has_src: assert property (|dma_start |-> |$past(src))
      else $error("dma start without event");
   a_dma_routed: assert property (|dma_start |-> |($past(src) & lvz))
      else $error("dma start from unrouted source");
   a_dma_single: assert property ($onehot($past(src)) |-> $onehot0(dma_start))
      else $error("one event gave several channels");
   c_dma: cover property (|dma_start);
   c_cpu: cover property (|cpu_irq_req);
   c_top: cover property (src32_level == 3'h7);
endmodule // imc_mode_ctrl_chk

/* File: verif/test_imc_mode_ctrl.sv */
module test_imc_mode_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [2:0]  src = 3'h0;
   logic [31:0] hrdata, rd, w;
   logic [2:0]  lv32, lv33, lv34, cpu_irq_req;
   logic [3:0]  dma_start;
   logic [7:0]  dma_seen;
   logic [1:0]  hresp;
   logic        hreadyout, irq;
   int          num_errors = 0, compares = 0;
   // 250 MHz clock
   always #2 hclk = ~hclk;
   imc_mode_ctrl imc_mode_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .serial4_transmit_irq(src[0]), .serial5_receive_irq(src[1]),
      .serial5_transmit_irq(src[2]), .src32_level(lv32), .src33_level(lv33),
      .src34_level(lv34), .cpu_irq_req(cpu_irq_req), .dma_start(dma_start), .irq(irq));
   imc_far_side imc_far_side_inst (.hclk(hclk), .hresetn(hresetn), .dma_start(dma_start),
      .dma_seen(dma_seen));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one ahb-lite single transfer, entered just after a rising edge
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   // one-cycle event on source i, then outputs compared with exp
   task automatic fire(input int i, input logic [31:0] exp);
      src[i] <= 1'b1;
      @(posedge hclk);
      src[i] <= 1'b0;
      #1 chk({16'h0, dma_start, cpu_irq_req, lv34, lv33, lv32}, exp);
      @(posedge hclk);
   endtask
   task automatic wrap_up();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // watchdog
   initial begin
      repeat (5000) @(posedge hclk);
      num_errors++;
      wrap_up();
   end
   // main sequence
   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      bus(0, imc_pkg::IMC_MODE_ADDR, 0);
      chk(rd, imc_pkg::IMC_MODE_RESET);
      chk(hresp, 2'h0);
      chk(hreadyout, 1'b1);
      bus(0, imc_pkg::IMC_MASK_ADDR, 0);
      chk(rd, 32'h0000_0000);
      bus(0, 32'hFFFF_E024, 0);
      chk(rd, 32'h0000_0000);
      bus(1, imc_pkg::IMC_MODE_ADDR, 32'hFFFF_FFFF);
      bus(0, imc_pkg::IMC_MODE_ADDR, 0);
      chk(rd, imc_pkg::IMC_MODE_WMASK);
      // every level code, edge bits 11 and top byte zero
      for (int l = 0; l < 8; l++) begin
         bus(1, imc_pkg::IMC_MODE_ADDR, 32'h0030_3030 | l | ((7 - l) << 8) | (l << 16));
         w = {2'b0, l[2:0], 3'(7 - l), l[2:0]};
         w[9 + l % 3] = (l % 3 == 1) ? (l != 7) : (l != 0);
         fire(l % 3, w);
      end
      // every channel code on a routed source, 100-111 refused
      for (int c = 0; c < 8; c++) begin
         bus(1, imc_pkg::IMC_MODE_ADDR, 32'h0030_3030 | ((32'h8 | c) << (8 * (c % 3))));
         fire(c % 3, (c < 4) ? (32'h1000 << c) : 32'h0);
      end
      chk(dma_seen, 8'h04);
      bus(0, imc_pkg::IMC_STAT_ADDR, 0);
      chk(rd, 32'h0000_0003);
      chk(irq, 1'b0);
      bus(1, imc_pkg::IMC_MASK_ADDR, 32'h0000_0001);
      #1 chk(irq, 1'b1);
      bus(1, imc_pkg::IMC_STAT_ADDR, 32'h0000_0001);
      #1 chk(irq, 1'b0);
      bus(0, imc_pkg::IMC_STAT_ADDR, 0);
      chk(rd, 32'h0000_0002);
      bus(1, imc_pkg::IMC_MASK_ADDR, 32'h0000_0002);
      #1 chk(irq, 1'b1);
      // edge bits left at 00: level path still works, status bit2 reports it
      bus(1, imc_pkg::IMC_MODE_ADDR, 32'h0000_0001);
      fire(0, 32'h0000_0201);
      bus(0, imc_pkg::IMC_STAT_ADDR, 0);
      chk(rd, 32'h0000_0006);
      chk(hresp, 2'h0);
      wrap_up();
   end
endmodule // test_imc_mode_ctrl

bind imc_mode_ctrl imc_mode_ctrl_chk imc_mode_ctrl_chk_inst (.hclk(hclk), .hresetn(hresetn),
   .serial4_transmit_irq(serial4_transmit_irq), .serial5_receive_irq(serial5_receive_irq),
   .serial5_transmit_irq(serial5_transmit_irq), .src32_level(src32_level),
   .src33_level(src33_level), .src34_level(src34_level), .cpu_irq_req(cpu_irq_req),
   .dma_start(dma_start));
